// >>> logic/mtd_core_ctl.sv
`timescale 1ns/100ps
// Functional notes
// - Swap operation exchanges source bytes into destination.
// - Every instruction carries a five-bit opcode.
// - Without eight-bit immediate, decode two-bit sub-op.
// - No interrupt for inactive or sync-waiting thread.
// - Acknowledge, finish instruction, save, handle, restore, resume.
// - No acknowledge while an interrupt is serviced.
// - Exceptions allowed in handler; none-interrupt during exception.
// - No acknowledge while the current instruction jumps.
// - Exception affects only its own thread.
// - Faulting instruction never writes the register file.
// - Exception saves PC, codes, instruction, registers; a dead-wait fault saves the PC, codes and instruction of the last issue fault.
// - Thread dies after handler; reset revives only thread 0, spawn revives any thread.
// - Illegal opcode or stray return raises illegal-instruction.
// - Misaligned load, store or jump target faults.
// - Jump into data or store into program faults.
// - Spawning an active thread faults the requester.
// - Waiting on a dead partner raises an exception.
// - Record holds one bit per exception cause.
// - Reading the fault record also clears it.
// - Return loads saved address and clears interrupt mask.
// - Debug bit controls zero register writability.
module mtd_core_ctl
	import mtd_pkg::*;
#(
	parameter logic [15:0] EXC_HANDLER_ADDR = 16'h0100
) (
	input  wire logic            clk,
	input  wire logic            reset_n,
	input  wire logic            issueValid,
	input  wire logic [1:0]      issueThread,
	input  wire logic [15:0]     issueInstr,
	input  wire logic [15:0]     issuePc,
	input  wire logic [15:0]     issueAddr,
	input  wire logic            issueJumpTaken,
	input  wire logic [15:0]     srcA,
	input  wire logic [7:0]      condCodes,
	input  wire logic [3:0]      threadWaiting,
	input  wire logic [3:0][3:0] waitPartners,
	input  wire logic [3:0]      intrReq,
	input  wire logic [15:0]     intrAddr,
	output logic      [3:0]      intrAck,
	output logic                 commitEn,
	output logic                 resultValid,
	output logic      [15:0]     resultData,
	output logic      [2:0]      resultReg,
	output logic      [3:0]      threadActive,
	output logic      [3:0]      threadHold,
	output logic      [3:0]      zeroRegWritable,
	output logic      [3:0]      intrMasked,
	output logic      [3:0]      excActive,
	output logic      [1:0]      ctxThread,
	output logic      [2:0]      rfIdx,
	input  wire logic [15:0]     rfRdData,
	output logic                 rfWrEn,
	output logic      [15:0]     rfWrData,
	output logic                 pcLoad,
	output logic      [1:0]      pcLoadThread,
	output logic      [15:0]     pcLoadValue,
	output logic                 ccLoad,
	output logic      [7:0]      ccLoadValue,
	output logic                 spawnValid,
	output logic      [1:0]      spawnThread
);
	if (EXC_HANDLER_ADDR[0] || EXC_HANDLER_ADDR[15]) begin
		$error("mtd_core_ctl: handler address must be even and in program memory");
	end

	typedef struct packed {
		logic [3:0]       reqMeta;
		logic [3:0]       reqSync;
		logic [15:0]      addrMeta;
		logic [15:0]      addrSync;
		logic [3:0]       active;
		logic [3:0]       inIsr;
		logic [3:0]       excBusy;
		logic [3:0]       savePend;
		logic [3:0]       debug;
		logic [3:0]       ack;
		logic [3:0][15:0] record;
		logic [3:0][15:0] isrAddr;
		logic [3:0][15:0] faultPc;
		logic [3:0][15:0] faultInstr;
		logic [3:0][7:0]  faultCc;
		mtd_eng_e         eng;
		logic [1:0]       engThread;
		logic             engKind;
		logic [3:0]       engCnt;
		logic             rstValid;
		logic [3:0]       rstSlot;
		logic [15:0]      engPc;
		logic [7:0]       engCc;
		logic [15:0]      engInstr;
		logic             commit;
		logic             resValid;
		logic [15:0]      resData;
		logic [2:0]       resReg;
		logic             pcLoad;
		logic [1:0]       pcThread;
		logic [15:0]      pcValue;
		logic             ccLoad;
		logic [7:0]       ccValue;
		logic             spawn;
		logic [1:0]       spawnTgt;
	} mtd_ctl_s;

	mtd_ctl_s r;
	mtd_ctl_s n;

	mtd_dec_if dec ();

	logic [1:0]       t;
	logic [3:0]       thrMask;
	logic [3:0]       busyMask;
	logic             engIdle;
	logic             retStall;
	logic             issueOk;
	logic             jumpUsed;
	logic             illegalHit;
	logic             misHit;
	logic             forbidHit;
	logic             spawnHit;
	logic [15:0]      issueExc;
	logic             anyExc;
	logic [3:0]       deadWait;
	logic             intrTake;
	logic [15:0]      memRdData;
	logic [15:0]      memWrData;

	assign dec.instr = issueInstr;

	mtd_decode u_decode (
		.bus (dec.dec)
	);

	assign t        = issueThread;
	assign thrMask  = 4'h1 << r.engThread;
	assign engIdle  = (r.eng == ENG_IDLE);
	assign busyMask = engIdle ? 4'h0 : thrMask;
	// A return cannot start its restore while the shared engine serves another thread.
	assign retStall = issueValid && dec.isReturn && r.inIsr[t] && !(engIdle && !(|r.savePend));
	assign threadHold = busyMask | r.savePend | (retStall ? (4'h1 << t) : 4'h0);
	assign issueOk  = issueValid && r.active[t] && !threadHold[t];

	assign jumpUsed   = dec.isJump && issueJumpTaken;
	assign illegalHit = !dec.legal || (dec.isReturn && !r.inIsr[t]);
	assign misHit     = (dec.isLoad || dec.isStore || jumpUsed) && issueAddr[0];
	assign forbidHit  = (jumpUsed && issueAddr[15]) || (dec.isStore && !issueAddr[15]);
	assign spawnHit   = dec.isSpawn && r.active[dec.spawnTarget];
	assign issueExc   = issueOk ? ((16'(illegalHit) << EXC_ILLEGAL)
		| (16'(misHit) << EXC_MISALIGNED)
		| (16'(forbidHit) << EXC_FORBIDDEN)
		| (16'(spawnHit) << EXC_SPAWN)) : 16'h0000;
	assign anyExc     = |issueExc;

	for (genvar g = 0; g < THREADS; g++) begin : g_dead
		// A killed partner shows as an inactive bit, which covers both wait cases.
		assign deadWait[g] = r.active[g] && threadWaiting[g]
			&& |(waitPartners[g] & ~r.active);
	end

	assign intrTake = issueOk && r.reqSync[t]
		&& !threadWaiting[t]
		&& !r.inIsr[t]
		&& !r.excBusy[t]
		&& !(dec.isJump || dec.isReturn)
		&& !dec.isPutMask && !dec.isKill && !anyExc
		&& engIdle && !(|r.savePend);

	always_comb begin
		logic [15:0] excNow;
		logic [1:0]  sel;
		excNow = 16'h0000;
		sel = 2'h0;
		n = r;
		n.reqMeta  = intrReq;
		n.reqSync  = r.reqMeta;
		n.addrMeta = intrAddr;
		n.addrSync = r.addrMeta;
		n.ack      = 4'h0;
		n.commit   = 1'b0;
		n.resValid = 1'b0;
		n.pcLoad   = 1'b0;
		n.ccLoad   = 1'b0;
		n.spawn    = 1'b0;
		n.rstValid = 1'b0;
		n.resReg   = dec.rd;

		for (int i = 0; i < THREADS; i++) begin
			excNow = (issueOk && (t == 2'(i))) ? issueExc : 16'h0000;
			excNow[EXC_DEADWAIT] = excNow[EXC_DEADWAIT] | (deadWait[i] && !r.excBusy[i]);
			if (issueOk && !anyExc && dec.isReadRecord && (t == 2'(i))) begin
				n.record[i] = EXR_RESET;
			end
			// Clear first and then set, so a fault in the same cycle survives the read.
			n.record[i] = n.record[i] | excNow;
			if ((|excNow) && !r.excBusy[i]) begin
				n.excBusy[i]  = 1'b1;
				n.savePend[i] = 1'b1;
				n.debug[i]    = 1'b1;
				if (issueOk && (t == 2'(i))) begin
					n.faultPc[i]    = issuePc;
					n.faultInstr[i] = issueInstr;
					n.faultCc[i]    = condCodes;
				end
			end
		end

		if (issueOk && !anyExc) begin
			n.commit   = 1'b1;
			n.resValid = dec.isSwap || dec.isReadRecord;
			n.resData  = dec.isSwap ? {srcA[7:0], srcA[15:8]} : r.record[t];
			if (dec.isPutDebug) begin
				n.debug[t] = dec.imm1;
			end
			if (dec.isPutMask) begin
				n.inIsr[t] = dec.imm1;
			end
			if (dec.isReturn) begin
				n.inIsr[t] = 1'b0;
			end
			if (dec.isKill) begin
				n.active[t]  = 1'b0;
				n.inIsr[t]   = 1'b0;
				n.excBusy[t] = 1'b0;
			end
			if (dec.isSpawn) begin
				n.active[dec.spawnTarget]  = 1'b1;
				n.excBusy[dec.spawnTarget] = 1'b0;
				n.spawn    = 1'b1;
				n.spawnTgt = dec.spawnTarget;
			end
		end

		unique case (r.eng)
			ENG_IDLE: begin
				if (intrTake) begin
					n.eng          = ENG_SAVE;
					n.engThread    = t;
					n.engKind      = KIND_INTR;
					n.engCnt       = SLOT_PC;
					n.engPc        = issuePc + RET_STEP;
					n.engCc        = condCodes;
					n.engInstr     = issueInstr;
					n.isrAddr[t]   = r.addrSync;
					n.ack[t]       = 1'b1;
					n.inIsr[t]     = 1'b1;
				end else if (issueOk && !anyExc && dec.isReturn) begin
					n.eng       = ENG_RESTORE;
					n.engThread = t;
					n.engCnt    = SLOT_PC;
				end else if (|r.savePend) begin
					for (int i = THREADS - 1; i >= 0; i--) begin
						if (r.savePend[i]) begin
							sel = 2'(i);
						end
					end
					n.eng         = ENG_SAVE;
					n.engThread   = sel;
					n.engKind     = KIND_EXC;
					n.engCnt      = SLOT_PC;
					n.engPc       = r.faultPc[sel];
					n.engCc       = r.faultCc[sel];
					n.engInstr    = r.faultInstr[sel];
					n.savePend[sel] = 1'b0;
				end
			end
			ENG_SAVE: begin
				if (r.engCnt == SLOT_LAST) begin
					n.eng      = ENG_IDLE;
					n.pcLoad   = 1'b1;
					n.pcThread = r.engThread;
					n.pcValue  = (r.engKind == KIND_EXC) ? EXC_HANDLER_ADDR
						: r.isrAddr[r.engThread];
				end else begin
					n.engCnt = r.engCnt + 4'h1;
				end
			end
			ENG_RESTORE: begin
				n.rstValid = 1'b1;
				n.rstSlot  = r.engCnt;
				if (r.engCnt == SLOT_LAST) begin
					n.eng = ENG_IDLE;
				end else begin
					n.engCnt = r.engCnt + 4'h1;
				end
			end
		endcase

		if (r.rstValid && (r.rstSlot == SLOT_PC)) begin
			n.pcLoad   = 1'b1;
			n.pcThread = r.engThread;
			n.pcValue  = memRdData;
		end
		if (r.rstValid && (r.rstSlot == SLOT_CC)) begin
			n.ccLoad  = 1'b1;
			n.ccValue = memRdData[7:0];
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			r        <= '0;
			r.active <= TAR_RESET;
		end else begin
			r <= n;
		end
	end

	always_comb begin
		unique case (r.engCnt)
			SLOT_PC:    memWrData = r.engPc;
			SLOT_CC:    memWrData = {8'h00, r.engCc};
			SLOT_INSTR: memWrData = r.engInstr;
			default:    memWrData = rfRdData;
		endcase
	end

	// Interrupt and exception frames sit apart so a fault inside a handler keeps the frame.
	mtd_ctx_mem #(
		.DATA_W (DATA_W),
		.ADDR_W (CTX_AW)
	) u_ctx_mem (
		.clk     (clk),
		.reset_n (reset_n),
		.wrEn    (r.eng == ENG_SAVE),
		.wrAddr  ({r.engKind, r.engThread, r.engCnt}),
		.wrData  (memWrData),
		.rdAddr  ({KIND_INTR, r.engThread, r.engCnt}),
		.rdData  (memRdData)
	);

	assign rfIdx    = (r.eng == ENG_SAVE) ? 3'(r.engCnt - SLOT_GPR0) : 3'(r.rstSlot - SLOT_GPR0);
	assign rfWrEn   = r.rstValid && (r.rstSlot >= SLOT_GPR0);
	assign rfWrData = memRdData;

	// Zero register opens for debug and while its frame moves in or out.
	assign zeroRegWritable = r.debug | busyMask | (r.rstValid ? thrMask : 4'h0);

	assign intrAck      = r.ack;
	assign commitEn     = r.commit;
	assign resultValid  = r.resValid;
	assign resultData   = r.resData;
	assign resultReg    = r.resReg;
	assign threadActive = r.active;
	assign intrMasked   = r.inIsr;
	assign excActive    = r.excBusy;
	assign ctxThread    = r.engThread;
	assign pcLoad       = r.pcLoad;
	assign pcLoadThread = r.pcThread;
	assign pcLoadValue  = r.pcValue;
	assign ccLoad       = r.ccLoad;
	assign ccLoadValue  = r.ccValue;
	assign spawnValid   = r.spawn;
	assign spawnThread  = r.spawnTgt;
endmodule

// >>> logic/mtd_pkg.sv
package mtd_pkg;
	localparam int          THREADS    = 4;
	localparam int          DATA_W     = 16;
	localparam int          OPC_MSB    = 15;
	localparam int          OPC_LSB    = 11;
	localparam int          SUB_MSB    = 10;
	localparam int          SUB_LSB    = 9;
	localparam int          RD_LSB     = 0;
	localparam int          IMM1_BIT   = 3;
	localparam int          SPAWN_LSB  = 3;
	localparam logic [4:0]  OP_SWAPGRP = 5'h0e;
	localparam logic [4:0]  OP_LOADGRP = 5'h0f;
	localparam logic [4:0]  OP_STORE   = 5'h10;
	localparam logic [4:0]  OP_THREAD  = 5'h12;
	localparam logic [4:0]  OP_JREG    = 5'h13;
	localparam logic [4:0]  OP_JALR    = 5'h14;
	localparam logic [4:0]  OP_JMPI    = 5'h15;
	localparam logic [4:0]  OP_JALI    = 5'h16;
	localparam logic [4:0]  OP_SYSGET  = 5'h19;
	localparam logic [4:0]  OP_SYSPUT  = 5'h1b;
	localparam logic [4:0]  OP_GETTHR  = 5'h1d;
	localparam logic [4:0]  OP_SWFT    = 5'h1e;
	localparam logic [1:0]  SUB_SWAP   = 2'h2;
	localparam logic [1:0]  SUB_LW     = 2'h0;
	localparam logic [1:0]  SUB_LWD    = 2'h2;
	localparam logic [1:0]  SUB_STMAX  = 2'h2;
	localparam logic [1:0]  SUB_KILL   = 2'h1;
	localparam logic [1:0]  SUB_SPAWN  = 2'h2;
	localparam logic [1:0]  SUB_GETREC = 2'h3;
	localparam logic [1:0]  SUB_PUTDBG = 2'h2;
	localparam logic [1:0]  SUB_PUTMSK = 2'h3;
	localparam logic [1:0]  SUB_GETTHR = 2'h0;
	localparam int          EXC_ILLEGAL    = 0;
	localparam int          EXC_MISALIGNED = 1;
	localparam int          EXC_FORBIDDEN  = 2;
	localparam int          EXC_SPAWN      = 3;
	localparam int          EXC_DEADWAIT   = 4;
	localparam logic [15:0] EXR_RESET  = 16'h0000;
	localparam logic [3:0]  TAR_RESET  = 4'h1;
	localparam logic [3:0]  SLOT_PC    = 4'h0;
	localparam logic [3:0]  SLOT_CC    = 4'h1;
	localparam logic [3:0]  SLOT_INSTR = 4'h2;
	localparam logic [3:0]  SLOT_GPR0  = 4'h3;
	localparam logic [3:0]  SLOT_LAST  = 4'ha;
	localparam int          CTX_AW     = 7;
	localparam logic        KIND_INTR  = 1'b0;
	localparam logic        KIND_EXC   = 1'b1;
	localparam logic [15:0] RET_STEP   = 16'h0002;

	typedef enum logic [1:0] {ENG_IDLE, ENG_SAVE, ENG_RESTORE} mtd_eng_e;
endpackage

// >>> logic/mtd_dec_if.sv
`timescale 1ns/100ps
interface mtd_dec_if;
	logic [15:0] instr;
	logic        legal;
	logic        isJump;
	logic        isReturn;
	logic        isLoad;
	logic        isStore;
	logic        isReadRecord;
	logic        isPutDebug;
	logic        isPutMask;
	logic        isKill;
	logic        isSpawn;
	logic        isSwap;
	logic        imm1;
	logic [1:0]  spawnTarget;
	logic [2:0]  rd;

	modport dec (input instr, output legal, isJump, isReturn, isLoad, isStore, isReadRecord,
		isPutDebug, isPutMask, isKill, isSpawn, isSwap, imm1, spawnTarget, rd);
	modport user (output instr, input legal, isJump, isReturn, isLoad, isStore, isReadRecord,
		isPutDebug, isPutMask, isKill, isSpawn, isSwap, imm1, spawnTarget, rd);
endinterface

// >>> logic/mtd_ctx_mem.sv
`timescale 1ns/100ps
module mtd_ctx_mem #(
	parameter int DATA_W = 16,
	parameter int ADDR_W = 7
) (
	input  wire logic              clk,
	input  wire logic              reset_n,
	input  wire logic              wrEn,
	input  wire logic [ADDR_W-1:0] wrAddr,
	input  wire logic [DATA_W-1:0] wrData,
	input  wire logic [ADDR_W-1:0] rdAddr,
	output logic      [DATA_W-1:0] rdData
);
	if (DATA_W < 1 || ADDR_W < 1 || ADDR_W > 10) begin
		$error("mtd_ctx_mem: unsupported geometry");
	end

	typedef struct packed {
		logic [(2**ADDR_W)-1:0][DATA_W-1:0] cells;
		logic [DATA_W-1:0]                  rd;
	} mtd_mem_s;

	mtd_mem_s r;
	mtd_mem_s n;

	always_comb begin
		n = r;
		n.rd = r.cells[rdAddr];
		if (wrEn) begin
			n.cells[wrAddr] = wrData;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign rdData = r.rd;
endmodule

// >>> logic/mtd_decode.sv
`timescale 1ns/100ps
module mtd_decode
	import mtd_pkg::*;
(
	mtd_dec_if.dec bus
);
	logic [4:0] opc;
	logic [1:0] sub;

	assign opc = bus.instr[OPC_MSB:OPC_LSB];
	assign sub = bus.instr[SUB_MSB:SUB_LSB];

	always_comb begin
		bus.legal        = 1'b1;
		bus.isJump       = 1'b0;
		bus.isReturn     = 1'b0;
		bus.isLoad       = 1'b0;
		bus.isStore      = 1'b0;
		bus.isReadRecord = 1'b0;
		bus.isPutDebug   = 1'b0;
		bus.isPutMask    = 1'b0;
		bus.isKill       = 1'b0;
		bus.isSpawn      = 1'b0;
		bus.isSwap       = 1'b0;
		bus.imm1         = bus.instr[IMM1_BIT];
		bus.spawnTarget  = bus.instr[SPAWN_LSB+:2];
		bus.rd           = bus.instr[RD_LSB+:3];
		unique case (opc)
			// The low sub-op bit is a don't-care for the swap variant.
			OP_SWAPGRP: bus.isSwap = (sub[1] == SUB_SWAP[1]);
			OP_LOADGRP: begin
				bus.legal  = (sub != 2'h3);
				bus.isLoad = (sub == SUB_LW) || (sub == SUB_LWD);
			end
			OP_STORE: begin
				bus.legal   = (sub <= SUB_STMAX);
				bus.isStore = bus.legal;
			end
			OP_THREAD: begin
				bus.legal   = (sub != 2'h3);
				bus.isKill  = (sub == SUB_KILL);
				bus.isSpawn = (sub == SUB_SPAWN);
			end
			OP_JREG: begin
				bus.isJump   = !bus.instr[SUB_LSB];
				bus.isReturn = bus.instr[SUB_LSB];
			end
			OP_JALR, OP_JMPI, OP_JALI: bus.isJump = 1'b1;
			OP_SYSGET: bus.isReadRecord = (sub == SUB_GETREC);
			OP_SYSPUT: begin
				bus.isPutDebug = (sub == SUB_PUTDBG);
				bus.isPutMask  = (sub == SUB_PUTMSK);
			end
			OP_GETTHR: bus.legal = (sub == SUB_GETTHR);
			OP_SWFT: bus.isStore = (sub == 2'h0);
			default: bus.legal = 1'b1;
		endcase
	end
endmodule

// >>> tb/mtd_checker.sv
`timescale 1ns/100ps
module mtd_checker
	import mtd_pkg::*;
(
	input logic        clk,
	input logic        reset_n,
	input logic        issueValid,
	input logic [1:0]  issueThread,
	input logic [15:0] issueInstr,
	input logic [15:0] issueAddr,
	input logic [15:0] srcA,
	input logic [3:0]  intrAck,
	input logic        commitEn,
	input logic        resultValid,
	input logic [15:0] resultData,
	input logic [3:0]  threadActive,
	input logic [3:0]  threadHold,
	input logic [3:0]  intrMasked,
	input logic [3:0]  excActive,
	input logic        pcLoad,
	input logic        spawnValid,
	input logic [1:0]  spawnThread
);
	logic       acc;
	logic [4:0] op;
	logic [1:0] sb;
	logic [1:0] tgt;
	logic       isJump;

	assign op     = issueInstr[15:11];
	assign sb     = issueInstr[10:9];
	assign tgt    = issueInstr[4:3];
	assign acc    = issueValid & threadActive[issueThread] & ~threadHold[issueThread];
	assign isJump = op == OP_JREG || op == OP_JALR || op == OP_JMPI || op == OP_JALI;

	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	a_swap_bytes:
		assert property (acc && op == OP_SWAPGRP && sb == SUB_SWAP
			|=> resultValid && {resultData[7:0], resultData[15:8]} == $past(srcA))
		else $error("swap result wrong");
	a_illegal_nocommit:
		assert property (acc && op == OP_LOADGRP && sb == 2'h3 |=> !commitEn)
		else $error("illegal opcode committed");
	a_misaligned_nocommit:
		assert property (acc && op == OP_LOADGRP && sb != 2'h3 && issueAddr[0] |=> !commitEn)
		else $error("odd load committed");
	a_forbidden_store:
		assert property (acc && op == OP_STORE && sb != 2'h3 && !issueAddr[15] |=> !commitEn)
		else $error("store to program memory committed");
	a_spawn_busy:
		assert property (acc && op == OP_THREAD && sb == SUB_SPAWN && threadActive[tgt]
			|=> !commitEn && !spawnValid)
		else $error("spawn of active thread accepted");
	a_spawn_start:
		assert property (acc && op == OP_THREAD && sb == SUB_SPAWN && !threadActive[tgt]
			|=> spawnValid && spawnThread == $past(tgt))
		else $error("spawn not started");
	a_masked_noack:
		assert property ((intrAck & $past(intrMasked)) == 4'h0)
		else $error("ack while interrupt in service");
	a_exc_noack:
		assert property ((intrAck & $past(excActive)) == 4'h0)
		else $error("ack while exception handled");
	a_idle_noack:
		assert property ((intrAck & ~$past(threadActive)) == 4'h0)
		else $error("ack for inactive thread");
	a_jump_noack:
		assert property (acc && isJump |=> intrAck == 4'h0)
		else $error("ack on a jump");
	a_ack_save:
		assert property (|intrAck |-> ##11 pcLoad)
		else $error("handler not entered after save");
	a_return_load:
		assert property (acc && op == OP_JREG && sb[0] && intrMasked[issueThread] |-> ##3 pcLoad)
		else $error("return did not load pc");
endmodule

bind mtd_core_ctl mtd_checker chk (.*);

// >>> tb/mtd_intr_dev.sv
`timescale 1ns/100ps
module mtd_intr_dev #(
	parameter logic [15:0] ISR_ADDR = 16'h0200
) (
	input  logic        clk,
	input  logic        reset_n,
	input  logic [3:0]  go,
	input  logic [3:0]  intrAck,
	output logic [3:0]  intrReq,
	output logic [15:0] intrAddr
);
	// A request is held until acknowledged, since the core may refuse it for a long time.
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			intrReq <= 4'h0;
		else
			intrReq <= (intrReq | go) & ~intrAck;
	end

	// With nothing pending the bus is undriven, so it toggles rather than holding a stale address.
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			intrAddr <= 16'h0000;
		else
			intrAddr <= (|(intrReq | go)) ? ISR_ADDR : ~intrAddr;
	end
endmodule

// >>> tb/tb_mt_dsp_decode_interrupt_exception.sv
`timescale 1ns/100ps
module tb_mt_dsp_decode_interrupt_exception
	import mtd_pkg::*;
;
	localparam logic [15:0] EXC_H = 16'h0100;
	localparam logic [15:0] ISR_A = 16'h0200;
	localparam logic [15:0] NOP_I = 16'hf800;

	logic             clk, reset_n, issueValid, issueJumpTaken, commitEn, resultValid, rfWrEn;
	logic             pcLoad, ccLoad, spawnValid, gotCommit;
	logic [1:0]       issueThread, ctxThread, pcLoadThread, spawnThread;
	logic [2:0]       resultReg, rfIdx, gotSp;
	logic [3:0]       intrAck, threadActive, threadHold, zeroRegWritable, intrMasked, excActive;
	logic [3:0]       intrReq, threadWaiting, go, gotAck, seen;
	logic [3:0][3:0]  waitPartners;
	logic [7:0]       condCodes, ccLoadValue;
	logic [15:0]      issueInstr, issuePc, issueAddr, srcA, intrAddr, resultData, rfRdData;
	logic [15:0]      rfWrData, pcLoadValue, gotData, savedPc;
	logic [15:0]      fIns [7];
	logic [15:0]      fAdr [7];
	int               fBit [7];
	int               errors, total_checks, cycles, n;

	mtd_core_ctl #(.EXC_HANDLER_ADDR(EXC_H)) dut (.*);
	mtd_intr_dev #(.ISR_ADDR(ISR_A)) dev (.clk(clk), .reset_n(reset_n), .go(go),
		.intrAck(intrAck), .intrReq(intrReq), .intrAddr(intrAddr));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic report_and_stop();
		if (errors == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 4000) begin
			errors++;
			$display("wrong value at %0t: run hung", $time);
			report_and_stop();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Presents one instruction once its thread is free and captures the registered answer.
	task automatic issue(input logic [1:0] t, input logic [15:0] ins, input logic [15:0] adr);
		n = 0;
		while (threadHold[t] !== 1'b0 && n < 40) begin
			@(negedge clk);
			n++;
		end
		issueThread = t;
		issueInstr = ins;
		issueAddr = adr;
		issuePc = issuePc + 16'h0002;
		srcA = srcA + 16'h1357;
		issueValid = 1'b1;
		@(negedge clk);
		issueValid = 1'b0;
		gotCommit = commitEn;
		gotData = resultData;
		gotAck = intrAck;
		gotSp = {spawnValid, spawnThread};
		// One idle edge keeps a following issue from re-raising valid in the same step.
		@(negedge clk);
	endtask

	task automatic waitLoad(input logic [1:0] t, input logic [15:0] exp);
		n = 0;
		while (pcLoad !== 1'b1 && n < 40) begin
			@(negedge clk);
			n++;
		end
		chk({14'h0, pcLoadThread}, {14'h0, t});
		chk({14'h0, ctxThread}, {14'h0, t});
		chk(pcLoadValue, exp);
		@(negedge clk);
	endtask

	task automatic takeIntr();
		gotAck = 4'h0;
		for (int k = 0; k < 12 && gotAck[0] !== 1'b1; k++)
			issue(2'h0, NOP_I, 16'h0);
		savedPc = issuePc;
		chk({12'h0, gotAck}, 16'h0001);
		waitLoad(2'h0, ISR_A);
		chk({12'h0, intrMasked}, 16'h0001);
	endtask

	task automatic retIntr();
		issue(2'h0, {OP_JREG, 2'h1, 9'h0}, 16'h0);
		chk({12'h0, intrMasked}, 16'h0000);
		waitLoad(2'h0, savedPc + RET_STEP);
		chk({7'h0, ccLoad, ccLoadValue}, 16'h01a5);
		@(negedge clk);
		chk(rfWrData, 16'h5a5a);
		chk({12'h0, rfWrEn, rfIdx}, 16'h0008);
	endtask

	initial begin
		reset_n = 1'b0;
		{issueValid, issueJumpTaken, issueThread, issueInstr, issuePc, issueAddr} = '0;
		{threadWaiting, waitPartners, condCodes, go} = '0;
		condCodes = 8'ha5;
		srcA = 16'h1234;
		rfRdData = 16'h5a5a;
		fIns = '{{OP_LOADGRP, 2'h3, 9'h0}, {OP_JREG, 2'h1, 9'h0}, {OP_LOADGRP, SUB_LW, 9'h0},
			{OP_STORE, 2'h0, 9'h0}, {OP_THREAD, SUB_SPAWN, 9'h0}, {OP_JMPI, 11'h0},
			{OP_JALR, 11'h0}};
		fAdr = '{16'h8000, 16'h8000, 16'h8001, 16'h1000, 16'h8000, 16'h8002, 16'h0041};
		fBit = '{EXC_ILLEGAL, EXC_ILLEGAL, EXC_MISALIGNED, EXC_FORBIDDEN, EXC_SPAWN,
			EXC_FORBIDDEN, EXC_MISALIGNED};
		repeat (4) @(negedge clk);
		reset_n = 1'b1;
		chk({12'h0, threadActive}, 16'h0001);
		issue(2'h0, {OP_SYSPUT, SUB_PUTDBG, 5'h0, 1'b1, 3'h0}, 16'h0);
		chk({12'h0, zeroRegWritable}, 16'h0001);
		issue(2'h0, {OP_SYSPUT, SUB_PUTDBG, 9'h0}, 16'h0);
		chk({12'h0, zeroRegWritable}, 16'h0000);
		go = 4'h1;
		@(negedge clk);
		go = 4'h0;
		takeIntr();
		go = 4'h1;
		seen = 4'h0;
		repeat (6) begin
			issue(2'h0, NOP_I, 16'h0);
			seen = seen | gotAck;
		end
		go = 4'h0;
		chk({12'h0, seen}, 16'h0000);
		retIntr();
		issueJumpTaken = 1'b1;
		issue(2'h0, {OP_JMPI, 11'h0}, 16'h0040);
		issueJumpTaken = 1'b0;
		chk({12'h0, gotAck}, 16'h0000);
		takeIntr();
		retIntr();
		// Jump condition stays true so the jump faults see a taken jump.
		issueJumpTaken = 1'b1;
		for (int i = 0; i < 7; i++) begin
			issue(2'h0, {OP_THREAD, SUB_SPAWN, 4'h0, 2'h1, 3'h0}, 16'h0);
			chk({15'h0, threadActive[1]}, 16'h0001);
			chk({13'h0, gotSp}, 16'h0005);
			issue(2'h1, fIns[i], fAdr[i]);
			chk({15'h0, gotCommit}, 16'h0000);
			issue(2'h0, {OP_SWAPGRP, SUB_SWAP, 9'h5}, 16'h0);
			chk(gotData, {srcA[7:0], srcA[15:8]});
			chk({15'h0, gotCommit}, 16'h0001);
			chk({13'h0, resultReg}, 16'h0005);
			waitLoad(2'h1, EXC_H);
			chk({15'h0, excActive[1]}, 16'h0001);
			issue(2'h1, {OP_SYSGET, SUB_GETREC, 9'h0}, 16'h0);
			chk(gotData, 16'h0001 << fBit[i]);
			issue(2'h1, {OP_SYSGET, SUB_GETREC, 9'h0}, 16'h0);
			chk(gotData, 16'h0000);
			issue(2'h1, {OP_THREAD, SUB_KILL, 9'h0}, 16'h0);
			chk({14'h0, excActive[1], threadActive[1]}, 16'h0000);
		end
		issueJumpTaken = 1'b0;
		threadWaiting = 4'h1;
		go = 4'h1;
		seen = 4'h0;
		repeat (4) begin
			issue(2'h0, NOP_I, 16'h0);
			seen = seen | gotAck;
		end
		chk({12'h0, seen}, 16'h0000);
		{threadWaiting, go} = '0;
		takeIntr();
		retIntr();
		// Thread 1 waits on thread 2, which is dead.
		issue(2'h0, {OP_THREAD, SUB_SPAWN, 4'h0, 2'h1, 3'h0}, 16'h0);
		threadWaiting = 4'h2;
		waitPartners[1] = 4'h4;
		waitLoad(2'h1, EXC_H);
		threadWaiting = 4'h0;
		issue(2'h1, {OP_SYSGET, SUB_GETREC, 9'h0}, 16'h0);
		chk(gotData, 16'h0001 << EXC_DEADWAIT);
		issue(2'h1, {OP_THREAD, SUB_KILL, 9'h0}, 16'h0);
		go = 4'h1;
		repeat (3) @(negedge clk);
		issue(2'h0, {OP_LOADGRP, 2'h3, 9'h0}, 16'h0);
		chk({12'h0, gotAck}, 16'h0000);
		waitLoad(2'h0, EXC_H);
		seen = 4'h0;
		repeat (4) begin
			issue(2'h0, NOP_I, 16'h0);
			seen = seen | gotAck;
		end
		chk({12'h0, seen}, 16'h0000);
		go = 4'h0;
		reset_n = 1'b0;
		@(negedge clk);
		reset_n = 1'b1;
		chk({8'h0, excActive, threadActive}, 16'h0001);
		report_and_stop();
	end
endmodule
